// ==== atf_pkg.sv ====
/*
 * Shared constants of the asynchronous serial channel: register offsets,
 * control field positions, reset values, frame states and timing figures.
 * Assumes a 100 MHz system clock and a 32-bit AHB-Lite register bus.
 */
package atf_pkg;

   // ==========================================================
   // Clock and rate figures
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned MAX_BPS_NORMAL = 19200;
   localparam int unsigned MAX_BPS_LOW_POWER = 600;
   localparam int unsigned OVERSAMPLE = 16;
   // Fastest legal rate sets the smallest divisor (rounded up)
   localparam int unsigned DIV_MIN_INT =
      (CLK_HZ + OVERSAMPLE * MAX_BPS_NORMAL - 1) /
      (OVERSAMPLE * MAX_BPS_NORMAL);
   localparam logic [15:0] DIV_MIN = 16'(DIV_MIN_INT);
   localparam logic [3:0] TICKS_PER_BIT_M1 = 4'(OVERSAMPLE - 1);
   localparam logic [3:0] TICKS_HALF_BIT_M1 = 4'(OVERSAMPLE / 2 - 1);

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_DATA = 8'h08;
   localparam logic [7:0] OFS_DIV = 8'h0C;
   localparam logic [7:0] OFS_GPIO = 8'h10;

   // ==========================================================
   // Control register fields
   localparam int CTL_PIN_EN = 0;
   localparam int CTL_MODE0 = 1;
   localparam int CTL_MODE1 = 2;
   localparam int CTL_PAR_EN = 3;
   localparam int CTL_PAR_ODD = 4;
   localparam int CTL_SRC0 = 5;
   localparam int CTL_SRC1 = 6;
   localparam int CTL_STOP2 = 7;
   localparam int CTL_MSB_FIRST = 8;
   localparam int CTL_TX_EN = 9;
   localparam int CTL_RX_EN = 10;
   localparam int CTL_TXIRQ_EN = 11;
   localparam int CTL_W = 12;
   localparam logic [11:0] CTL_RST = 12'h000;

   // Command (write) and status (read) register fields
   localparam int CMD_TX_TRIG = 0;
   localparam int CMD_RX_ACK = 1;
   localparam int ST_TX_BUSY = 0;
   localparam int ST_TX_DONE = 1;
   localparam int ST_RX_DONE = 2;
   localparam int ST_PAR_ERR = 3;
   localparam int ST_FRM_ERR = 4;
   localparam int ST_OVR_ERR = 5;

   // GPIO register fields and divisor reset value
   localparam int GPIO_OUT_LSB = 0;
   localparam int GPIO_DIR_LSB = 4;
   localparam int GPIO_IN_LSB = 8;
   localparam logic [15:0] DIV_RST = 16'h0146;

   // Pin indices
   localparam int PIN_SIN = 0;
   localparam int PIN_SOUT = 1;

   localparam logic [1:0] SRC_TIMER = 2'h0;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_WAIT = 3'b001,
      TX_START = 3'b010,
      TX_DATA = 3'b011,
      TX_PAR = 3'b100,
      TX_STOP1 = 3'b101,
      TX_STOP2 = 3'b110
   } atf_tx_state_e;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b000,
      RX_START = 3'b001,
      RX_DATA = 3'b010,
      RX_PAR = 3'b011,
      RX_STOP = 3'b100
   } atf_rx_state_e;

endpackage

// ==== atf_serial.sv ====
/*
 * Asynchronous serial channel with AHB-Lite register access: framing,
 * transmit path, parity generation and check, full-duplex receiver and
 * pin multiplexing with four general-purpose pins.
 * Assumes one 100 MHz clock, a single AHB-Lite master, a timer tick
 * pulse on the same clock and pins that come from outside the clock domain.
 */
`timescale 1ns/1ps
module atf_serial (
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_ARST_N,
   // AHB-Lite slave
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic [31:0] I_HWDATA,
   input wire logic I_HREADY,
   output logic [31:0] O_HRDATA,
   output logic O_HREADYOUT,
   output logic O_HRESP,
   // Shift clock sources
   input wire logic I_TMR_TICK,
   input wire logic I_HSOSC_ON,
   // Pins: serial in, serial out, two general-purpose
   input wire logic [3:0] I_PIN,
   output logic [3:0] O_PIN,
   output logic [3:0] O_PIN_OE,
   // Transmit complete interrupt
   output logic O_TX_IRQ
);

   // ==========================================================
   // Helpers
   function automatic logic [7:0] order_bits(input logic [7:0] d,
                                             input logic msb_first,
                                             input logic eight);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++) begin
         r[i] = d[7 - i];
      end
      if (!msb_first) begin
         order_bits = eight ? d : {1'b0, d[6:0]};
      end else begin
         order_bits = eight ? r : {1'b0, r[7:1]};
      end
   endfunction

   function automatic logic calc_parity(input logic [7:0] d,
                                        input logic eight,
                                        input logic odd);
      logic p;
      p = eight ? ^d : ^d[6:0];
      calc_parity = p ^ odd;
   endfunction

   // ==========================================================
   // Pin synchronisers
   logic [3:0] pin_s1_r;
   logic [3:0] pin_s2_r;

   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         pin_s1_r <= 4'h0;
         pin_s2_r <= 4'h0;
      end else begin
         pin_s1_r <= I_PIN;
         pin_s2_r <= pin_s1_r;
      end
   end

   // ==========================================================
   // Register state
   logic [atf_pkg::CTL_W-1:0] ctl_r;
   logic [15:0] div_r;
   logic [7:0] gpio_out_r;
   logic [7:0] tx_data_r;
   logic [7:0] rx_buf_r;
   logic tx_done_r;
   logic rx_done_r;
   logic par_err_r;
   logic frm_err_r;
   logic ovr_err_r;

   logic ph_wr_r;
   logic [7:0] ph_addr_r;
   logic addr_phase;

   assign addr_phase = I_HSEL && I_HTRANS[1] && I_HREADY;

   wire pin_en = ctl_r[atf_pkg::CTL_PIN_EN];
   wire async_mode = ctl_r[atf_pkg::CTL_MODE1];
   wire eight_bit = ctl_r[atf_pkg::CTL_MODE0];
   wire par_en = ctl_r[atf_pkg::CTL_PAR_EN];
   wire par_odd = ctl_r[atf_pkg::CTL_PAR_ODD];
   wire [1:0] clk_src = {ctl_r[atf_pkg::CTL_SRC1], ctl_r[atf_pkg::CTL_SRC0]};
   wire tx_en = ctl_r[atf_pkg::CTL_TX_EN];
   wire rx_en = ctl_r[atf_pkg::CTL_RX_EN];

   wire wr_ctl = ph_wr_r && ph_addr_r == atf_pkg::OFS_CTRL;
   wire wr_cmd = ph_wr_r && ph_addr_r == atf_pkg::OFS_CMD;
   wire wr_data = ph_wr_r && ph_addr_r == atf_pkg::OFS_DATA;
   wire wr_div = ph_wr_r && ph_addr_r == atf_pkg::OFS_DIV;
   wire wr_gpio = ph_wr_r && ph_addr_r == atf_pkg::OFS_GPIO;
   wire tx_trig = wr_cmd && I_HWDATA[atf_pkg::CMD_TX_TRIG];
   wire rx_ack = wr_cmd && I_HWDATA[atf_pkg::CMD_RX_ACK];

   atf_pkg::atf_tx_state_e tx_st_r;
   atf_pkg::atf_rx_state_e rx_st_r;

   // ==========================================================
   // Bus slave: zero wait states, read data captured at address phase
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         ph_wr_r <= 1'b0;
         ph_addr_r <= 8'h00;
         O_HREADYOUT <= 1'b1;
         O_HRESP <= 1'b0;
      end else begin
         ph_wr_r <= addr_phase && I_HWRITE;
         ph_addr_r <= I_HADDR[7:0];
         O_HREADYOUT <= 1'b1;
         O_HRESP <= 1'b0;
      end
   end

   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_HRDATA <= 32'h0000_0000;
      end else if (addr_phase && !I_HWRITE) begin
         case (I_HADDR[7:0])
            atf_pkg::OFS_CTRL: O_HRDATA <= 32'(ctl_r);
            atf_pkg::OFS_CMD: O_HRDATA <= 32'({ovr_err_r, frm_err_r,
               par_err_r, rx_done_r, tx_done_r,
               tx_st_r != atf_pkg::TX_IDLE});
            atf_pkg::OFS_DATA: O_HRDATA <= 32'(rx_buf_r);
            atf_pkg::OFS_DIV: O_HRDATA <= 32'(div_r);
            atf_pkg::OFS_GPIO: O_HRDATA <= 32'({pin_s2_r, gpio_out_r});
            default: O_HRDATA <= 32'h0000_0000;
         endcase
      end
   end

   // Byte lanes are not decoded: only whole-word transfers are supported
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         ctl_r <= atf_pkg::CTL_RST;
         div_r <= atf_pkg::DIV_RST;
         gpio_out_r <= 8'h00;
         tx_data_r <= 8'h00;
      end else begin
         if (wr_ctl) begin
            ctl_r <= I_HWDATA[atf_pkg::CTL_W-1:0];
         end
         if (wr_div) begin
            // Below the floor the rate would exceed the supported maximum
            div_r <= (I_HWDATA[15:0] < atf_pkg::DIV_MIN) ?
                     atf_pkg::DIV_MIN : I_HWDATA[15:0];
         end
         if (wr_gpio) begin
            gpio_out_r <= I_HWDATA[7:0];
         end
         if (wr_data) begin
            tx_data_r <= I_HWDATA[7:0];
         end
      end
   end

   // ==========================================================
   // Oversampling tick: timer pulse or divided oscillator
   logic [15:0] div_cnt_r;
   logic tick;

   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         div_cnt_r <= 16'h0000;
      end else if (!I_HSOSC_ON || div_cnt_r == 16'h0000) begin
         div_cnt_r <= div_r - 16'h0001;
      end else begin
         div_cnt_r <= div_cnt_r - 16'h0001;
      end
   end

   // Oscillator off stops the divided source entirely
   assign tick = (clk_src == atf_pkg::SRC_TIMER) ? I_TMR_TICK :
                 (I_HSOSC_ON && div_cnt_r == 16'h0000);

   // ==========================================================
   // Transmitter
   logic [3:0] tx_sub_r;
   logic [2:0] tx_bit_r;
   logic [7:0] tx_sh_r;
   logic tx_par_r;
   logic tx_line_r;
   wire tx_bit_end = tick && tx_sub_r == 4'h0;
   wire [2:0] last_bit = eight_bit ? 3'h7 : 3'h6;

   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         tx_st_r <= atf_pkg::TX_IDLE;
         tx_sub_r <= 4'h0;
         tx_bit_r <= 3'h0;
         tx_sh_r <= 8'h00;
         tx_par_r <= 1'b0;
         tx_line_r <= 1'b1;
      end else if (!tx_en) begin
         tx_st_r <= atf_pkg::TX_IDLE;
         tx_line_r <= 1'b1;
      end else begin
         if (tick) begin
            tx_sub_r <= tx_sub_r - 4'h1;
         end
         case (tx_st_r)
            atf_pkg::TX_IDLE: begin
               tx_line_r <= 1'b1;
               if (tx_trig && async_mode) begin
                  tx_sh_r <= order_bits(tx_data_r,
                     ctl_r[atf_pkg::CTL_MSB_FIRST],
                     eight_bit);
                  tx_par_r <= calc_parity(tx_data_r, eight_bit,
                     par_odd);
                  tx_st_r <= atf_pkg::TX_WAIT;
               end
            end
            atf_pkg::TX_WAIT: begin
               // Start bit lines up with the next shift clock tick
               if (tick) begin
                  tx_line_r <= 1'b0;
                  tx_sub_r <= atf_pkg::TICKS_PER_BIT_M1;
                  tx_st_r <= atf_pkg::TX_START;
               end
            end
            atf_pkg::TX_START: begin
               if (tx_bit_end) begin
                  tx_line_r <= tx_sh_r[0];
                  tx_sh_r <= {1'b0, tx_sh_r[7:1]};
                  tx_bit_r <= 3'h0;
                  tx_sub_r <= atf_pkg::TICKS_PER_BIT_M1;
                  tx_st_r <= atf_pkg::TX_DATA;
               end
            end
            atf_pkg::TX_DATA: begin
               if (tx_bit_end) begin
                  tx_sub_r <= atf_pkg::TICKS_PER_BIT_M1;
                  if (tx_bit_r != last_bit) begin
                     tx_line_r <= tx_sh_r[0];
                     tx_sh_r <= {1'b0, tx_sh_r[7:1]};
                     tx_bit_r <= tx_bit_r + 3'h1;
                  end else if (par_en) begin
                     tx_line_r <= tx_par_r;
                     tx_st_r <= atf_pkg::TX_PAR;
                  end else begin
                     tx_line_r <= 1'b1;
                     tx_st_r <= atf_pkg::TX_STOP1;
                  end
               end
            end
            atf_pkg::TX_PAR: begin
               if (tx_bit_end) begin
                  tx_line_r <= 1'b1;
                  tx_sub_r <= atf_pkg::TICKS_PER_BIT_M1;
                  tx_st_r <= atf_pkg::TX_STOP1;
               end
            end
            atf_pkg::TX_STOP1: begin
               if (tx_bit_end) begin
                  tx_sub_r <= atf_pkg::TICKS_PER_BIT_M1;
                  tx_st_r <= ctl_r[atf_pkg::CTL_STOP2] ?
                     atf_pkg::TX_STOP2 : atf_pkg::TX_IDLE;
               end
            end
            atf_pkg::TX_STOP2: begin
               if (tx_bit_end) begin
                  tx_st_r <= atf_pkg::TX_IDLE;
               end
            end
            default: tx_st_r <= atf_pkg::TX_IDLE;
         endcase
      end
   end

   wire tx_finish = tx_en && tx_bit_end &&
      ((tx_st_r == atf_pkg::TX_STOP1 && !ctl_r[atf_pkg::CTL_STOP2]) ||
       tx_st_r == atf_pkg::TX_STOP2);

   // Set wins over a simultaneous write-one-to-clear
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         tx_done_r <= 1'b0;
         O_TX_IRQ <= 1'b0;
      end else begin
         if (tx_finish) begin
            tx_done_r <= 1'b1;
         end else if (wr_cmd && I_HWDATA[atf_pkg::ST_TX_DONE]) begin
            tx_done_r <= 1'b0;
         end
         O_TX_IRQ <= (tx_done_r || tx_finish) &&
                     ctl_r[atf_pkg::CTL_TXIRQ_EN];
      end
   end

   // ==========================================================
   // Receiver, separate shifter from the transmitter
   logic [3:0] rx_sub_r;
   logic [2:0] rx_bit_r;
   logic [7:0] rx_sh_r;
   logic rx_par_bit_r;
   wire rx_in = pin_en ? pin_s2_r[atf_pkg::PIN_SIN] : 1'b1;
   wire rx_bit_end = tick && rx_sub_r == 4'h0;
   wire rx_store = rx_st_r == atf_pkg::RX_STOP && rx_bit_end;
   wire [7:0] rx_rev = order_bits(rx_sh_r, 1'b1, 1'b1);
   wire [7:0] rx_data = ctl_r[atf_pkg::CTL_MSB_FIRST] ?
      (eight_bit ? rx_rev : {1'b0, rx_rev[6:0]}) :
      (eight_bit ? rx_sh_r : {1'b0, rx_sh_r[7:1]});

   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         rx_st_r <= atf_pkg::RX_IDLE;
         rx_sub_r <= 4'h0;
         rx_bit_r <= 3'h0;
         rx_sh_r <= 8'h00;
         rx_par_bit_r <= 1'b0;
      end else if (!rx_en || !async_mode) begin
         rx_st_r <= atf_pkg::RX_IDLE;
      end else begin
         if (tick) begin
            rx_sub_r <= rx_sub_r - 4'h1;
         end
         case (rx_st_r)
            atf_pkg::RX_IDLE: begin
               if (tick && !rx_in) begin
                  rx_sub_r <= atf_pkg::TICKS_HALF_BIT_M1;
                  rx_st_r <= atf_pkg::RX_START;
               end
            end
            atf_pkg::RX_START: begin
               if (rx_bit_end) begin
                  rx_sub_r <= atf_pkg::TICKS_PER_BIT_M1;
                  rx_bit_r <= 3'h0;
                  // A glitch shorter than half a bit is not a start
                  rx_st_r <= rx_in ? atf_pkg::RX_IDLE : atf_pkg::RX_DATA;
               end
            end
            atf_pkg::RX_DATA: begin
               if (rx_bit_end) begin
                  rx_sub_r <= atf_pkg::TICKS_PER_BIT_M1;
                  rx_sh_r <= {rx_in, rx_sh_r[7:1]};
                  rx_bit_r <= rx_bit_r + 3'h1;
                  if (rx_bit_r == last_bit) begin
                     rx_st_r <= par_en ? atf_pkg::RX_PAR : atf_pkg::RX_STOP;
                  end
               end
            end
            atf_pkg::RX_PAR: begin
               if (rx_bit_end) begin
                  rx_sub_r <= atf_pkg::TICKS_PER_BIT_M1;
                  rx_par_bit_r <= rx_in;
                  rx_st_r <= atf_pkg::RX_STOP;
               end
            end
            atf_pkg::RX_STOP: begin
               if (rx_bit_end) begin
                  rx_st_r <= atf_pkg::RX_IDLE;
               end
            end
            default: rx_st_r <= atf_pkg::RX_IDLE;
         endcase
      end
   end

   // Receive flags: error sets win over software clears; an ack in the store cycle raises overrun and leaves done unchanged
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         rx_buf_r <= 8'h00;
         rx_done_r <= 1'b0;
         par_err_r <= 1'b0;
         frm_err_r <= 1'b0;
         ovr_err_r <= 1'b0;
      end else if (!rx_en) begin
         par_err_r <= 1'b0;
         frm_err_r <= 1'b0;
         ovr_err_r <= 1'b0;
      end else if (rx_store) begin
         rx_buf_r <= rx_data;
         if (rx_done_r || rx_ack) begin
            ovr_err_r <= 1'b1;
         end else begin
            rx_done_r <= 1'b1;
         end
         if (par_en && calc_parity(rx_data, eight_bit, par_odd) !=
             rx_par_bit_r) begin
            par_err_r <= 1'b1;
         end
         if (!rx_in) begin
            frm_err_r <= 1'b1;
         end
      end else begin
         if (rx_ack) begin
            rx_done_r <= 1'b0;
         end
         if (wr_cmd && I_HWDATA[atf_pkg::ST_PAR_ERR]) begin
            par_err_r <= 1'b0;
         end
         if (wr_cmd && I_HWDATA[atf_pkg::ST_FRM_ERR]) begin
            frm_err_r <= 1'b0;
         end
         if (wr_cmd && I_HWDATA[atf_pkg::ST_OVR_ERR]) begin
            ovr_err_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Pin multiplexer
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_PIN <= 4'h0;
         O_PIN_OE <= 4'h0;
      end else begin
         O_PIN <= gpio_out_r[atf_pkg::GPIO_OUT_LSB +: 4];
         O_PIN_OE <= gpio_out_r[atf_pkg::GPIO_DIR_LSB +: 4];
         if (pin_en) begin
            O_PIN[atf_pkg::PIN_SIN] <= 1'b0;
            O_PIN_OE[atf_pkg::PIN_SIN] <= 1'b0;
            O_PIN[atf_pkg::PIN_SOUT] <= tx_line_r;
            O_PIN_OE[atf_pkg::PIN_SOUT] <= 1'b1;
         end
      end
   end

endmodule

// ==== atf_monitor.sv ====
/*
 * Port checker of the serial channel, bound to atf_serial.
 * Assumes one clock domain and an always-ready single-slave bus.
 */
`timescale 1ns/1ps
module atf_monitor (
   // Clock, reset and bus
   input wire logic I_CLK,
   input wire logic I_ARST_N,
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic I_HREADY,
   input wire logic [31:0] O_HRDATA,
   input wire logic O_HREADYOUT,
   input wire logic O_HRESP,
   // Pins and interrupt
   input wire logic [3:0] O_PIN,
   input wire logic [3:0] O_PIN_OE,
   input wire logic O_TX_IRQ
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_ARST_N);
   // ==========
   // Bus phase tracking
   wire logic take = I_HSEL && I_HTRANS[1] && I_HREADY;
   logic wr_ph_r;
   logic unm_ph_r;
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         wr_ph_r <= 1'b0;
         unm_ph_r <= 1'b0;
      end else begin
         wr_ph_r <= take && I_HWRITE;
         unm_ph_r <= take && !I_HWRITE && I_HADDR[7:0] > 8'h13;
      end
   end
   // ==========
   // Properties
   a_resp_okay: assert property (O_HRESP == 1'b0)
      else $error("error response seen");
   a_ready_high: assert property (O_HREADYOUT)
      else $error("wait state inserted");
   a_unmapped_zero: assert property (unm_ph_r |-> O_HRDATA == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property ($changed(O_HRDATA) |->
      $past(take && !I_HWRITE)) else $error("read data moved unasked");
   a_oe_by_write: assert property ($changed(O_PIN_OE) |->
      $past(wr_ph_r) || $past(wr_ph_r, 2) || $past(wr_ph_r, 3))
      else $error("pin direction moved without a write");
   a_start_min: assert property ($fell(O_PIN[1]) &&
      O_PIN_OE[1] |-> (!O_PIN[1]) [*8]) else $error("start bit too short");
   a_idle_on: assert property ($rose(O_PIN_OE[1]) |-> O_PIN[1])
      else $error("line not high when taken over");
   a_stop_irq: assert property ($rose(O_TX_IRQ) |-> O_PIN[1] &&
      $past(O_PIN[1], 8) && $past(O_PIN[1], 14))
      else $error("done without stop level");
   c_frame_done: cover property ($rose(O_TX_IRQ));
   c_unmapped: cover property (unm_ph_r);
   c_serial_on: cover property ($rose(O_PIN_OE[1]));
endmodule

bind atf_serial atf_monitor mon_u (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
   .I_HSEL(I_HSEL), .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS),
   .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA),
   .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_PIN(O_PIN),
   .O_PIN_OE(O_PIN_OE), .O_TX_IRQ(O_TX_IRQ));

// ==== atf_remote.sv ====
/*
 * Remote transceiver model: captures the serial output and echoes it back.
 * Assumes a fixed count of system clocks per bit and an idle-high line.
 */
`timescale 1ns/1ps
module atf_remote #(
   parameter int BIT_CLKS = 16
) (
   // Clock
   input wire logic i_clk,
   // Serial lines
   input wire logic i_line,
   output logic o_line,
   // Capture
   output logic [11:0] o_cap,
   output int o_frames
);
   // Echo one clock late keeps the receiver busy alongside the transmitter
   initial o_line = 1'b1;
   always @(posedge i_clk) o_line <= i_line;
   initial o_frames = 0;
   initial o_cap = 12'h000;
   // Mid-bit sampling; twelve samples cover the longest frame, shorter ones reach into idle
   always begin
      @(negedge i_line);
      repeat (BIT_CLKS / 2) @(posedge i_clk);
      for (int k = 0; k < 12; k++) begin
         o_cap[k] = i_line;
         repeat (BIT_CLKS) @(posedge i_clk);
      end
      o_frames++;
   end
endmodule

// ==== tb_top.sv ====
/*
 * Testbench of the serial channel: bus tasks and framing checks.
 * Timer tick held high, so one bit is sixteen clocks.
 */
`timescale 1ns/1ps
module tb_top;
   logic I_CLK = 1'b0;
   logic I_ARST_N = 1'b0;
   logic I_HSEL = 1'b0;
   logic I_HWRITE = 1'b0;
   logic [1:0] I_HTRANS = 2'h0;
   logic [31:0] I_HADDR = 32'h0000_0000;
   logic [31:0] I_HWDATA = 32'h0000_0000;
   logic osc = 1'b0;
   logic [31:0] O_HRDATA;
   logic O_HREADYOUT, O_HRESP, O_TX_IRQ, rl;
   logic [3:0] O_PIN, O_PIN_OE, pin;
   logic [11:0] cap;
   int frames, fail_count = 0, cmp_count = 0, cyc = 0;
   always #5 I_CLK = ~I_CLK;
   // Undriven pins float high, except pin 0, which takes the remote echo
   always_comb for (int k = 0; k < 4; k++)
      pin[k] = O_PIN_OE[k] ? O_PIN[k] : (k == 0 ? rl : 1'b1);
   atf_serial dut_u (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_HSEL(I_HSEL),
      .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE),
      .I_HSIZE(3'h2), .I_HWDATA(I_HWDATA), .I_HREADY(O_HREADYOUT),
      .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
      .I_TMR_TICK(1'b1), .I_HSOSC_ON(osc), .I_PIN(pin), .O_PIN(O_PIN),
      .O_PIN_OE(O_PIN_OE), .O_TX_IRQ(O_TX_IRQ));
   atf_remote rem_u (.i_clk(I_CLK), .i_line(pin[1]), .o_line(rl),
      .o_cap(cap), .o_frames(frames));
   // ==========
   // Checking and bus tasks
   task chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task give_verdict;
      if (fail_count == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      @(posedge I_CLK);
      I_HSEL <= 1'b1;
      I_HTRANS <= 2'h2;
      I_HADDR <= {24'h00_0000, a};
      I_HWRITE <= w;
      do @(posedge I_CLK); while (O_HREADYOUT !== 1'b1);
      I_HTRANS <= 2'h0;
      I_HSEL <= 1'b0;
      I_HWDATA <= wd;
      do @(posedge I_CLK); while (O_HREADYOUT !== 1'b1);
      rd = O_HRDATA;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] t;
      bus(1'b1, a, d, t);
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] t;
      bus(1'b0, a, 32'h0000_0000, t);
      chk(t, e);
   endtask
   function automatic logic [31:0] cfg(logic e, p, o, s, m, t);
      logic [31:0] c;
      c = 32'h0000_0000;
      c[atf_pkg::CTL_PIN_EN] = 1'b1;
      c[atf_pkg::CTL_MODE1] = 1'b1;
      c[atf_pkg::CTL_MODE0] = e;
      c[atf_pkg::CTL_PAR_EN] = p;
      c[atf_pkg::CTL_PAR_ODD] = o;
      c[atf_pkg::CTL_STOP2] = s;
      c[atf_pkg::CTL_MSB_FIRST] = m;
      c[atf_pkg::CTL_TX_EN] = t;
      c[atf_pkg::CTL_RX_EN] = t;
      c[atf_pkg::CTL_TXIRQ_EN] = 1'b1;
      return c;
   endfunction
   // Line samples, start first; idle and stops read as ones
   function automatic logic [11:0] frm(logic [7:0] d, logic e, p, o, m);
      logic [11:0] f;
      int n;
      f = 12'hFFE;
      n = e ? 8 : 7;
      for (int k = 0; k < n; k++) f[1 + k] = m ? d[n - 1 - k] : d[k];
      if (p) f[1 + n] = ^d[6:0] ^ (e & d[7]) ^ o;
      return f;
   endfunction
   // ==========
   // Hang guard
   always @(posedge I_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         give_verdict();
      end
   end
   // ==========
   // Main sequence
   initial begin
      logic [31:0] v;
      logic [7:0] d;
      logic e, p, o, s, m;
      int n, fb;
      repeat (16) @(posedge I_CLK);
      I_ARST_N <= 1'b1;
      @(posedge I_CLK);
      chk(32'(O_PIN_OE), 32'h0000_0000);
      rchk(atf_pkg::OFS_CTRL, 32'h0000_0000);
      rchk(atf_pkg::OFS_DIV, 32'(atf_pkg::DIV_RST));
      rchk(8'h40, 32'h0000_0000);
      wr(atf_pkg::OFS_DIV, 32'h0000_0001);
      rchk(atf_pkg::OFS_DIV, 32'(atf_pkg::DIV_MIN));
      wr(atf_pkg::OFS_CTRL, 32'h0000_0000);
      wr(atf_pkg::OFS_GPIO, 32'h0000_00C4);
      wr(atf_pkg::OFS_CTRL, cfg(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
      repeat (3) @(posedge I_CLK);
      chk(32'({O_PIN_OE[3:2], O_PIN[3:2]}), 32'h0000_000D);
      chk(32'(pin[1]), 32'h0000_0001);
      for (int i = 0; i < 8; i++) begin
         {o, p, e} = 3'(i);
         s = o ^ e;
         m = e ^ p;
         d = 8'hA7 + 8'(i * 29);
         fb = 2 + (e ? 8 : 7) + 32'(p) + 32'(s);
         chk(32'(frames), 32'(i));
         wr(atf_pkg::OFS_CTRL, cfg(e, p, o, s, m, 1'b1));
         wr(atf_pkg::OFS_DATA, {24'h00_0000, d});
         wr(atf_pkg::OFS_CMD, 32'h0000_0001);
         wr(atf_pkg::OFS_CMD, 32'h0000_0001);
         n = 0;
         while (O_TX_IRQ !== 1'b1 && n < 400) begin
            @(posedge I_CLK);
            n++;
         end
         chk(32'(n >= fb * 16 - 6 && n <= fb * 16 + 6), 1);
         n = 0;
         while (frames != i + 1 && n < 400) begin
            @(posedge I_CLK);
            n++;
         end
         chk(32'(cap), 32'(frm(d, e, p, o, m)));
         rchk(atf_pkg::OFS_CMD, 32'h0000_0006);
         rchk(atf_pkg::OFS_DATA, 32'({e, 7'h7F} & d));
         wr(atf_pkg::OFS_CMD, 32'h0000_0002);
         rchk(atf_pkg::OFS_CMD, 32'h0000_0000);
         chk(32'(O_TX_IRQ), 32'h0000_0000);
      end
      // Abort mid-frame, then a trigger while disabled
      wr(atf_pkg::OFS_CTRL, cfg(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1));
      wr(atf_pkg::OFS_DATA, 32'h0000_00FF);
      wr(atf_pkg::OFS_CMD, 32'h0000_0001);
      repeat (60) @(posedge I_CLK);
      wr(atf_pkg::OFS_CTRL, cfg(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
      repeat (3) @(posedge I_CLK);
      chk(32'(pin[1]), 32'h0000_0001);
      bus(1'b0, atf_pkg::OFS_CMD, 32'h0000_0000, v);
      chk(32'(v[0]), 32'h0000_0000);
      wr(atf_pkg::OFS_CMD, 32'h0000_0001);
      repeat (200) @(posedge I_CLK);
      chk(32'(pin[1]), 32'h0000_0001);
      chk(32'(frames), 32'h0000_0009);
      // Divided source: no tick while the oscillator is off
      wr(atf_pkg::OFS_CTRL, cfg(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1) |
         (32'h0000_0001 << atf_pkg::CTL_SRC0));
      wr(atf_pkg::OFS_CMD, 32'h0000_0001);
      repeat (50) @(posedge I_CLK);
      bus(1'b0, atf_pkg::OFS_CMD, 32'h0000_0000, v);
      chk(32'(v[0]), 32'h0000_0001);
      chk(32'(pin[1]), 32'h0000_0001);
      osc <= 1'b1;
      repeat (340) @(posedge I_CLK);
      chk(32'(pin[1]), 32'h0000_0000);
      give_verdict();
   end
endmodule
